/* dsr_pkg.sv */
// Constants and carriers shared by the status/configuration register block.
// Assumes one device clock domain and one serial-clock domain at the link.
package dsr_pkg;

	localparam logic [6:0]  ADDR_STATUS   = 7'h02;
	localparam logic [6:0]  ADDR_SPI_CFG  = 7'h03;
	localparam logic [6:0]  ADDR_GEN_CFG  = 7'h04;
	localparam logic [6:0]  ADDR_BRD_CFG  = 7'h05;
	localparam logic [6:0]  ADDR_BRD_DATA = 7'h0f;
	localparam logic [6:0]  ADDR_ID       = 7'h01;
	localparam logic [6:0]  ADDR_NOP      = 7'h00;

	localparam logic [15:0] RST_STATUS    = 16'h0000;
	localparam logic [15:0] RST_SPI_CFG   = 16'h0aa4;
	localparam logic [15:0] RST_GEN_CFG   = 16'h7f00;
	localparam logic [15:0] RST_BRD_CFG   = 16'hffff;

	// Writable bits and read-only constant bits of the serial and general config registers
	localparam logic [15:0] SPI_CFG_WMASK = 16'h0e7e;
	localparam logic [15:0] SPI_CFG_FIXED = 16'h0080;
	localparam logic [15:0] GEN_CFG_WMASK = 16'h40ff;
	localparam logic [15:0] GEN_CFG_FIXED = 16'h3f00;

	localparam int ST_CHECK_ERR   = 2;
	localparam int ST_PENDING     = 1;
	localparam int ST_OVERTEMP    = 0;
	localparam int SPI_OT_ROUTE   = 11;
	localparam int SPI_PEND_ROUTE = 10;
	localparam int SPI_CHK_ROUTE  = 9;
	localparam int SPI_SOFT_TOG   = 6;
	localparam int SPI_DEV_SLEEP  = 5;
	localparam int SPI_CHECK_EN   = 4;
	localparam int SPI_STREAM     = 3;
	localparam int SPI_SERIAL_OUT_ENABLE     = 2;
	localparam int SPI_EARLY_EDGE = 1;
	localparam int GEN_REF_SLEEP  = 14;

	localparam logic [5:0]  FRAME_SHORT   = 6'd24;
	localparam logic [5:0]  FRAME_LONG    = 6'd32;
	localparam logic [7:0]  CRC_POLY      = 8'h07;
	localparam logic [7:0]  CRC_INIT      = 8'h00;

	typedef struct packed {
		logic        long_frame;
		logic [31:0] bits;
	} dsr_frame_s;

	typedef struct packed {
		logic check_en;
		logic serial_out_enable;
		logic early_edge;
	} dsr_link_cfg_s;

endpackage : dsr_pkg

/* dsr_spi_link.sv */
// Serial-clock side of the register port: frame capture and read-data shifting.
// Assumes sclk runs only while cs_n is low; cfg and read_word change rarely.
`timescale 1ns/1ps
module dsr_spi_link
	import dsr_pkg::*;
(
	input  wire logic          sclk,        // Serial clock from host
	input  wire logic          rst,         // Device reset, async high
	input  wire logic          cs_n,        // Frame select, low active
	input  wire logic          sdi,         // Serial data in
	input  wire dsr_link_cfg_s cfg,         // Link options, device clock domain
	input  wire logic [15:0]   read_word,   // Read data held by device side
	output logic               sdo,         // Serial data out
	output logic               sdo_oe,      // Drive enable for sdo
	output dsr_frame_s         frame,       // Last complete frame
	output logic               frame_toggle // Flips once per complete frame
);

	dsr_link_cfg_s cfg_s1;
	dsr_link_cfg_s cfg_s2;
	logic [5:0]    bit_cnt;
	logic [31:0]   rx;
	logic [23:0]   tx;
	logic          early_bit;

	// Options settle only while the clock runs, so a change lands a frame late
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			cfg_s1 <= '0;
			cfg_s2 <= '0;
		end else begin
			cfg_s1 <= cfg;
			cfg_s2 <= cfg_s1;
		end
	end

	wire       frame_clr = rst | cs_n;
	wire [5:0] frame_len = cfg_s2.check_en ? FRAME_LONG : FRAME_SHORT;
	wire       last_bit  = (bit_cnt == frame_len - 6'd1);
	wire       in_frame  = (bit_cnt != frame_len);

	// Counter is cleared by the frame's own select, not by a clock edge
	always_ff @(posedge sclk or posedge frame_clr) begin
		if (frame_clr)
			bit_cnt <= '0;
		else if (in_frame)
			bit_cnt <= bit_cnt + 6'd1;
	end

	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			rx           <= '0;
			frame        <= '0;
			frame_toggle <= 1'b0;
		end else begin
			if (in_frame)
				rx <= {rx[30:0], sdi};
			if (last_bit) begin
				frame.bits       <= {rx[30:0], sdi};
				frame.long_frame <= cfg_s2.check_en;
				frame_toggle     <= ~frame_toggle;
			end
		end
	end

	always_ff @(posedge sclk or posedge rst) begin
		if (rst)
			tx <= '0;
		else if (bit_cnt == 6'd0)
			tx <= {8'h00, read_word};
		else
			tx <= {tx[22:0], 1'b0};
	end

	// Falling-edge copy presents the next bit half a cycle early
	always_ff @(negedge sclk or posedge rst) begin
		if (rst)
			early_bit <= 1'b0;
		else
			early_bit <= tx[22];
	end

	assign sdo    = cfg_s2.early_edge ? early_bit : tx[23];
	assign sdo_oe = cfg_s2.serial_out_enable & ~cs_n;

endmodule : dsr_spi_link

/* dsr_regs.sv */
// Status and configuration register bank reached over the serial port.
// Assumes overtemp_detect is asynchronous and update_pending comes from clk logic.
`timescale 1ns/1ps
module dsr_regs
	import dsr_pkg::*;
#(
	parameter int CHANNELS = 16
)(
	input  wire logic                    clk,                      // Device clock, 125 MHz
	input  wire logic                    rst,                      // Async reset, high
	input  wire logic                    sclk,                     // Serial clock from host
	input  wire logic                    cs_n,                     // Frame select, low
	input  wire logic                    sdi,                      // Serial data in
	output logic                         sdo,                      // Serial data out
	output logic                         sdo_oe,                   // High while sdo is driven
	input  wire logic                    overtemp_detect,          // Temperature comparator, async
	input  wire logic                    update_pending,           // Channel data not ready
	output logic                         alarm_out_pin,            // Alarm output, high
	output logic [CHANNELS-1:0]          channel_sleep,            // Per-channel power-down
	output logic                         device_sleep,             // Whole-device power-down
	output logic                         reference_sleep,          // Reference power-down
	output logic                         software_toggle_enable,   // Soft toggle mode
	output logic                         streaming_enable,         // Streaming mode
	output logic [CHANNELS/2-1:0]        pair_differential_enable, // Per-pair differential
	output logic [CHANNELS-1:0]          broadcast_enable,         // Per-channel broadcast
	output logic                         channel_wr_valid,         // Write to other register
	output logic [6:0]                   channel_wr_addr,          // Its address
	output logic [15:0]                  channel_wr_data           // Its data
);

	if (CHANNELS != 16) begin : g_check
		$error("dsr_regs supports sixteen channels only");
	end

	// Link side and crossing
	dsr_frame_s    frame;
	logic          frame_toggle;
	logic          tog_s1;
	logic          tog_s2;
	logic          tog_prev;
	logic          ot_s1;
	logic          ot_sync;
	logic [15:0]   read_word;
	logic [15:0]   spi_cfg;
	logic [15:0]   gen_cfg;
	logic [15:0]   brd_cfg;
	logic          chk_flag;
	logic          ot_flag;
	dsr_link_cfg_s link_cfg;

	assign link_cfg.check_en   = spi_cfg[SPI_CHECK_EN];
	assign link_cfg.serial_out_enable     = spi_cfg[SPI_SERIAL_OUT_ENABLE];
	assign link_cfg.early_edge = spi_cfg[SPI_EARLY_EDGE];

	dsr_spi_link u_link (
		.sclk         (sclk),
		.rst          (rst),
		.cs_n         (cs_n),
		.sdi          (sdi),
		.cfg          (link_cfg),
		.read_word    (read_word),
		.sdo          (sdo),
		.sdo_oe       (sdo_oe),
		.frame        (frame),
		.frame_toggle (frame_toggle)
	);

	// Frame word is held until the next frame, far longer than the sync delay
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tog_s1   <= 1'b0;
			tog_s2   <= 1'b0;
			tog_prev <= 1'b0;
			ot_s1    <= 1'b0;
			ot_sync  <= 1'b0;
		end else begin
			tog_s1   <= frame_toggle;
			tog_s2   <= tog_s1;
			tog_prev <= tog_s2;
			ot_s1    <= overtemp_detect;
			ot_sync  <= ot_s1;
		end
	end

	function automatic logic [7:0] crc8(input logic [23:0] d);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 23; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
		return c;
	endfunction : crc8

	// Frame decode
	wire        frame_evt  = tog_s2 ^ tog_prev;
	wire [23:0] payload    = frame.long_frame ? frame.bits[31:8] : frame.bits[23:0];
	wire        crc_bad    = frame.long_frame && (crc8(payload) != frame.bits[7:0]);
	wire        is_read    = payload[23];
	wire [6:0]  addr       = payload[22:16];
	wire [15:0] wdata      = payload[15:0];
	wire        frame_ok   = frame_evt & ~crc_bad;
	wire        wr         = frame_ok & ~is_read;
	wire        rd         = frame_ok & is_read;
	wire        hit_status = (addr == ADDR_STATUS);
	wire        hit_spi    = (addr == ADDR_SPI_CFG);
	wire        hit_gen    = (addr == ADDR_GEN_CFG);
	wire        hit_brd    = (addr == ADDR_BRD_CFG);
	wire        hit_local  = hit_status | hit_spi | hit_gen | hit_brd;
	wire        any_diff   = |gen_cfg[CHANNELS/2-1:0];
	wire        brd_block  = (addr == ADDR_BRD_DATA) & any_diff;
	wire        hit_fixed  = (addr == ADDR_NOP) | (addr == ADDR_ID);
	wire        rd_status  = rd & hit_status;

	// Read views with reserved bits at their fixed values
	wire [15:0] status_rd = {13'h0000, chk_flag, update_pending, ot_flag};
	wire [15:0] spi_rd    = (spi_cfg & SPI_CFG_WMASK) | SPI_CFG_FIXED;
	wire [15:0] gen_rd    = (gen_cfg & GEN_CFG_WMASK) | GEN_CFG_FIXED;
	wire [15:0] rd_mux    = hit_status ? status_rd :
	                        hit_spi    ? spi_rd :
	                        hit_gen    ? gen_rd :
	                        hit_brd    ? brd_cfg : 16'h0000;

	// Flag updates: a new event in the clearing cycle wins over the clear
	wire next_chk_flag = (frame_evt & crc_bad) | (chk_flag & ~rd_status);
	wire next_ot_flag  = ot_sync | (ot_flag & ~rd_status);

	// Alarm sources: pending is a live level, the others are sticky flags
	wire next_alarm = (ot_flag & spi_cfg[SPI_OT_ROUTE])
	                | (update_pending & spi_cfg[SPI_PEND_ROUTE])
	                | (chk_flag & spi_cfg[SPI_CHK_ROUTE]);

	wire next_wr_valid = wr & ~hit_local & ~hit_fixed & ~brd_block;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chk_flag <= RST_STATUS[ST_CHECK_ERR];
			ot_flag  <= RST_STATUS[ST_OVERTEMP];
		end else begin
			chk_flag <= next_chk_flag;
			ot_flag  <= next_ot_flag;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			spi_cfg <= RST_SPI_CFG;
			gen_cfg <= RST_GEN_CFG;
			brd_cfg <= RST_BRD_CFG;
		end else if (wr) begin
			if (hit_spi)
				spi_cfg <= wdata & SPI_CFG_WMASK;
			if (hit_gen)
				gen_cfg <= wdata & GEN_CFG_WMASK;
			if (hit_brd)
				brd_cfg <= wdata;
		end
	end

	// Read data goes out in the following frame
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			read_word <= '0;
		else if (rd)
			read_word <= rd_mux;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alarm_out_pin    <= 1'b0;
			channel_wr_valid <= 1'b0;
			channel_wr_addr  <= '0;
			channel_wr_data  <= '0;
		end else begin
			alarm_out_pin    <= next_alarm;
			channel_wr_valid <= next_wr_valid;
			channel_wr_addr  <= addr;
			channel_wr_data  <= wdata;
		end
	end

	// Power-down per channel: device sleep or a thermal event
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_sleep
		always_ff @(posedge clk or posedge rst) begin
			if (rst)
				channel_sleep[ch] <= 1'b1;
			else
				channel_sleep[ch] <= spi_cfg[SPI_DEV_SLEEP] | next_ot_flag;
		end
	end

	assign device_sleep             = spi_cfg[SPI_DEV_SLEEP];
	assign software_toggle_enable   = spi_cfg[SPI_SOFT_TOG];
	assign streaming_enable         = spi_cfg[SPI_STREAM];
	assign reference_sleep          = gen_cfg[GEN_REF_SLEEP];
	assign pair_differential_enable = gen_cfg[CHANNELS/2-1:0];
	assign broadcast_enable         = brd_cfg;

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_bad_frame;
		frame_evt && crc_bad;
	endsequence

	sequence s_status_read;
		frame_ok && is_read && hit_status;
	endsequence

	sequence s_spi_write;
		frame_ok && !is_read && hit_spi;
	endsequence

	a_check_flag_set: assert property (s_bad_frame |=> chk_flag [*1] ##0 !channel_wr_valid)
		else $error("frame-check flag not set after bad frame");

	a_pending_status: assert property (s_status_read ##0 update_pending |=> read_word[ST_PENDING])
		else $error("pending bit missing from status read");

	// A status read may clear the flag right after, so power-down is checked with the flag itself
	a_overtemp_latch: assert property (ot_sync |=> ot_flag && channel_sleep == '1)
		else $error("over-temperature not latched");

	a_sleep_forced: assert property (ot_flag |-> channel_sleep == '1)
		else $error("channels not powered down on thermal alarm");

	a_ot_route: assert property (ot_flag && spi_cfg[SPI_OT_ROUTE] |=> alarm_out_pin)
		else $error("thermal alarm not routed to pin");

	a_pending_clear: assert property (
		!update_pending && !chk_flag && !ot_flag |=> !alarm_out_pin)
		else $error("alarm pin held without any source");

	a_pending_route: assert property (
		update_pending && spi_cfg[SPI_PEND_ROUTE] |=> alarm_out_pin)
		else $error("pending alarm not routed to pin");

	a_chk_route: assert property (chk_flag && spi_cfg[SPI_CHK_ROUTE] |=> alarm_out_pin)
		else $error("frame-check alarm not routed to pin");

	a_spi_write_view: assert property (
		s_spi_write |=> spi_rd == (($past(wdata) & SPI_CFG_WMASK) | SPI_CFG_FIXED))
		else $error("serial config readback wrong");

	a_gen_fixed: assert property (rd && hit_gen |=> !read_word[15] && read_word[13:8] == 6'h3f)
		else $error("general config reserved bits wrong");

	a_brd_block: assert property (wr && brd_block |=> !channel_wr_valid)
		else $error("broadcast write passed while a pair is differential");

	a_brd_forward: assert property (
		wr && addr == ADDR_BRD_DATA && !any_diff |=> channel_wr_valid && channel_wr_addr == ADDR_BRD_DATA)
		else $error("broadcast write dropped with no differential pair");

	a_local_kept: assert property (wr && hit_local |=> !channel_wr_valid)
		else $error("local register write leaked to channel side");

	a_brd_write: assert property (wr && hit_brd |=> brd_cfg == $past(wdata))
		else $error("broadcast enable write lost");

	a_ref_sleep: assert property (wr && hit_gen |=> reference_sleep == $past(wdata[GEN_REF_SLEEP]))
		else $error("reference power-down not taken from write");

	a_dev_sleep: assert property (spi_cfg[SPI_DEV_SLEEP] |=> channel_sleep == '1)
		else $error("channels active while device is powered down");

	// Good status read with no new event must leave both sticky flags clear
	a_check_flag_clear: assert property (rd_status |=> !chk_flag)
		else $error("frame-check flag survived a status read");

	a_ot_flag_clear: assert property (rd_status && !ot_sync |=> !ot_flag)
		else $error("over-temperature flag survived a status read");

endmodule : dsr_regs

/* dsr_host_model.sv */
// Host controller model driving the serial register port of the bank.
// Assumes the device samples sdi on sclk rise and only drives sdo while sdo_oe is high.
`timescale 1ns/1ps
module dsr_host_model
	import dsr_pkg::*;
(
	output logic      sclk,   // Serial clock, still outside frames except during kick
	output logic      cs_n,   // Frame select, low active
	output logic      sdi,    // Serial data to device
	input  wire logic sdo,    // Serial data from device
	input  wire logic sdo_oe  // Device drives sdo
);
	logic last_bit;
	logic oe_seen;
	// No pull on the line: a released line shows the inverse of the last level
	wire  sdo_line = sdo_oe ? sdo : ~last_bit;

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
		last_bit = 1'b0;
		oe_seen = 1'b0;
	end

	function automatic logic [7:0] crc8(input logic [23:0] w);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 23; i >= 0; i--) begin
			c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction : crc8

	// Two idle edges so the link side sees reset
	task automatic kick();
		repeat (2) begin
			sclk = 1'b1;
			#15;
			sclk = 1'b0;
			#15;
		end
	endtask : kick

	// Data changes 4 ns after each fall but the last; sdo is taken at that moment for the first 24 bits
	task automatic xfer(input logic [23:0] w, input logic chk, input logic bad, output logic [23:0] cap);
		logic [31:0] f;
		int          n;
		f = {w, crc8(w) ^ {8{bad}}};
		n = chk ? 32 : 24;
		cap = '0;
		cs_n = 1'b0;
		sdi = f[31];
		// Even lead after an odd start time keeps sclk rises off the device clock edges
		#14;
		for (int i = 0; i < n; i++) begin
			sclk = 1'b1;
			#15;
			sclk = 1'b0;
			#4;
			if (i < 24) begin
				cap = {cap[22:0], sdo_line};
				last_bit = sdo_line;
				oe_seen = oe_seen | sdo_oe;
			end
			if (i < n - 1)
				sdi = f[30-i];
			#11;
		end
		cs_n = 1'b1;
		sdi = ~sdi;
		#60;
	endtask : xfer
endmodule : dsr_host_model

/* test_dsr_regs.sv */
// Self-checking bench for the status/configuration register bank.
// Assumes dsr_host_model stands in for the serial host on the far side.
`timescale 1ns/1ps
module test_dsr_regs
	import dsr_pkg::*;
;
	logic        clk, rst, overtemp_detect, update_pending;
	logic        sclk, cs_n, sdi, sdo, sdo_oe, alarm_out_pin;
	logic [15:0] channel_sleep, broadcast_enable, channel_wr_data, wr_data;
	logic        device_sleep, reference_sleep, software_toggle_enable, streaming_enable;
	logic [7:0]  pair_differential_enable;
	logic        channel_wr_valid, crc_on, early;
	logic [6:0]  channel_wr_addr, wr_addr;
	int          failures, n_checks, n_wr;

	dsr_host_model host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
	dsr_regs #(.CHANNELS(16)) dut (
		.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
		.overtemp_detect(overtemp_detect), .update_pending(update_pending),
		.alarm_out_pin(alarm_out_pin), .channel_sleep(channel_sleep), .device_sleep(device_sleep),
		.reference_sleep(reference_sleep), .software_toggle_enable(software_toggle_enable),
		.streaming_enable(streaming_enable), .pair_differential_enable(pair_differential_enable),
		.broadcast_enable(broadcast_enable), .channel_wr_valid(channel_wr_valid),
		.channel_wr_addr(channel_wr_addr), .channel_wr_data(channel_wr_data));

	initial clk = 1'b0;
	always #4 clk = ~clk;

	always @(posedge clk) begin
		if (channel_wr_valid === 1'b1) begin
			n_wr <= n_wr + 1;
			wr_addr <= channel_wr_addr;
			wr_data <= channel_wr_data;
		end
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wclk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wclk

	// Settle covers the sync into the clk domain
	task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic bad = 1'b0);
		logic [23:0] c;
		host.xfer({1'b0, a, d}, crc_on, bad, c);
		wclk(8);
	endtask : wr

	// Read data comes back in the following frame
	task automatic rd(input logic [6:0] a, input logic [15:0] e);
		logic [23:0] c;
		host.xfer({1'b1, a, 16'h0000}, crc_on, 1'b0, c);
		host.xfer({1'b0, ADDR_NOP, 16'h0000}, crc_on, 1'b0, c);
		wclk(8);
		if (early)
			chk(c[23:1], {7'h00, e});
		else
			chk(c, {8'h00, e});
	endtask : rd

	task automatic done(input string s);
		$display("%s finished, checks %0d", s, n_checks);
	endtask : done

	task automatic end_of_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	initial begin
		#200000;
		failures++;
		end_of_test();
	end

	initial begin
		rst = 1'b1;
		overtemp_detect = 1'b0;
		update_pending = 1'b0;
		crc_on = 1'b0;
		early = 1'b0;
		failures = 0;
		n_checks = 0;
		n_wr = 0;
		host.kick();
		wclk(10);
		rst = 1'b0;
		wclk(3);
		chk({channel_sleep, device_sleep, reference_sleep, software_toggle_enable, streaming_enable,
			pair_differential_enable, broadcast_enable, alarm_out_pin},
			{16'hffff, 4'b1100, 8'h00, 16'hffff, 1'b0});
		rd(ADDR_STATUS, 16'h0000);
		rd(ADDR_SPI_CFG, 16'h0aa4);
		rd(ADDR_GEN_CFG, 16'h7f00);
		rd(ADDR_BRD_CFG, 16'hffff);
		done("reset values");
		wr(ADDR_SPI_CFG, 16'h954d);
		rd(ADDR_SPI_CFG, 16'h04cc);
		chk({device_sleep, software_toggle_enable, streaming_enable, channel_sleep}, {3'b011, 16'h0000});
		wr(ADDR_GEN_CFG, 16'hc0a5);
		rd(ADDR_GEN_CFG, 16'h7fa5);
		chk({reference_sleep, pair_differential_enable}, {1'b1, 8'ha5});
		wr(ADDR_GEN_CFG, 16'h0001);
		rd(ADDR_GEN_CFG, 16'h3f01);
		chk({reference_sleep, pair_differential_enable}, {1'b0, 8'h01});
		done("config registers");
		n_wr = 0;
		wr(ADDR_BRD_DATA, 16'h1234);
		chk(n_wr, 0);
		wr(7'h10, 16'h5a5a);
		chk({n_wr[7:0], wr_addr, wr_data}, {8'd1, 7'h10, 16'h5a5a});
		wr(ADDR_GEN_CFG, 16'h0000);
		wr(ADDR_BRD_DATA, 16'h4321);
		chk({n_wr[7:0], wr_addr, wr_data}, {8'd2, ADDR_BRD_DATA, 16'h4321});
		wr(ADDR_BRD_CFG, 16'h1234);
		rd(ADDR_BRD_CFG, 16'h1234);
		chk(broadcast_enable, 16'h1234);
		done("broadcast");
		update_pending = 1'b1;
		wclk(5);
		chk(alarm_out_pin, 1'b1);
		rd(ADDR_STATUS, 16'h0002);
		update_pending = 1'b0;
		wclk(5);
		chk(alarm_out_pin, 1'b0);
		overtemp_detect = 1'b1;
		wclk(6);
		chk({alarm_out_pin, channel_sleep}, {1'b0, 16'hffff});
		overtemp_detect = 1'b0;
		rd(ADDR_STATUS, 16'h0001);
		rd(ADDR_STATUS, 16'h0000);
		wr(ADDR_SPI_CFG, 16'h0ccc);
		overtemp_detect = 1'b1;
		wclk(5);
		overtemp_detect = 1'b0;
		wclk(5);
		chk(alarm_out_pin, 1'b1);
		rd(ADDR_STATUS, 16'h0001);
		chk(alarm_out_pin, 1'b0);
		done("alarms");
		wr(ADDR_SPI_CFG, 16'h0a1c);
		crc_on = 1'b1;
		wr(ADDR_BRD_CFG, 16'habcd);
		chk(broadcast_enable, 16'habcd);
		wr(ADDR_BRD_CFG, 16'h0000, 1'b1);
		chk({broadcast_enable, alarm_out_pin}, {16'habcd, 1'b1});
		rd(ADDR_STATUS, 16'h0004);
		done("frame check");
		wr(ADDR_SPI_CFG, 16'h0a1e);
		early = 1'b1;
		host.oe_seen = 1'b0;
		rd(ADDR_GEN_CFG, 16'h3f00);
		chk(host.oe_seen, 1'b1);
		wr(ADDR_SPI_CFG, 16'h0a18);
		early = 1'b0;
		wr(ADDR_NOP, 16'h0000);
		host.oe_seen = 1'b0;
		wr(ADDR_NOP, 16'h0000);
		chk(host.oe_seen, 1'b0);
		done("serial output");
		end_of_test();
	end
endmodule : test_dsr_regs
